// [design/queued_spi_scan.sv]
// Queued serial master that scans a converter from a 16-entry command queue.
// Assumes one 25 MHz clock, a slave that samples on rising SCK, and that miso is a raw pin.
// What this block does
// - Serial clock idles low; outgoing data changes on falling edges, sampled rising.
// - Serial clock rate is system clock over twice the divider value.
// - High and low clock phases each last exactly half a serial period.
// - Long pre-clock delay puts first edge pre-count cycles after select.
// - Without long pre-clock delay, first edge follows select by half period.
// - Selects stay unchanged half a period after the final clock edge.
// - Post-transfer delay waits 32 cycles times post count before next entry.
// - At least half a period between last falling edge and next select, plus 32 times post count if post delay is on.
// - Programmed word length sets bits per transfer; ten for converter use.
// - Entry uses programmed length only if its length enable is set, else eight.
// - Each entry sends its transmit word and stores received word in its slot.
// - Queue may start at entry F once, then loop entries 0-2 forever.
// - Finished flag sets when end-pointer entry completes.
// - Entry time is bits times period plus its delays, no extra idle.
// - Master may select another peripheral while a conversion runs.
// - Hold clear drives default selects only in post delay or after a non-wrapping end entry, else next entry's follow at once; hold set keeps entry's.
// - After end entry with wrap, continue at entry 0 or start pointer.
`timescale 1ns/10ps
`include "queued_spi_consts.svh"
module queued_spi_scan #(
  parameter int FIFO_DEPTH = `QS_FIFO_DEPTH
) (
  input  wire logic                   clock_in,
  input  wire logic                   reset_n_in,
  input  wire logic                   queue_write_in,
  input  wire logic [3:0]             queue_index_in,
  input  wire logic [15:0]            queue_tx_word_in,
  input  wire queued_spi_pkg::cmd_t   queue_cmd_in,
  input  wire logic [3:0]             rx_index_in,
  output      logic [15:0]            rx_word_out,
  input  wire logic [7:0]             clock_divider_in,
  input  wire logic [4:0]             word_bits_in,
  input  wire logic [7:0]             pre_clock_delay_count_in,
  input  wire logic [7:0]             post_transfer_delay_count_in,
  input  wire logic [3:0]             default_selects_in,
  input  wire logic [3:0]             queue_start_pointer_in,
  input  wire logic [3:0]             queue_end_pointer_in,
  input  wire logic                   queue_wrap_enable_in,
  input  wire logic                   wrap_target_select_in,
  input  wire logic                   start_in,
  input  wire logic                   stop_in,
  input  wire logic                   clear_finished_in,
  output      logic                   running_out,
  output      logic                   queue_finished_flag_out,
  output      logic [3:0]             completed_pointer_out,
  output      logic                   sck_out,
  output      logic                   mosi_out,
  input  wire logic                   miso_in,
  output      logic [3:0]             peripheral_selects_out,
  output      logic                   result_valid_out,
  input  wire logic                   result_ready_in,
  output      queued_spi_pkg::result_t result_data_out
);

  // Half period in system cycles; a zero divider is taken as one
  function automatic logic [15:0] half_cycles(input logic [7:0] div);
    half_cycles = (div == 8'h00) ? 16'h0001 : {8'h00, div};
  endfunction

  queued_spi_pkg::state_t  state_q, state_d;
  queued_spi_pkg::cmd_t    cmd_mem [`QS_QUEUE_DEPTH];
  queued_spi_pkg::cmd_t    cmd_q, cmd_d;
  queued_spi_pkg::result_t push_data;
  logic [15:0] tx_mem [`QS_QUEUE_DEPTH];
  logic [15:0] rx_mem [`QS_QUEUE_DEPTH];
  logic [15:0] tx_q, tx_d, rx_q, rx_d, cnt_q, cnt_d, pre_q, pre_d, half;
  logic [4:0]  bits_q, bits_d, idx_q, idx_d, len;
  logic [3:0]  ptr_q, ptr_d, cs_q, cs_d, done_q, done_d, lp;
  logic        sck_q, sck_d, mosi_q, mosi_d, fin_q, fin_d, halt_q, halt_d;
  logic        launch, complete, fifo_ready, fifo_valid;
  logic [2:0]  miso_s;
  logic        miso_q, miso_d;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser: a change counts once the second and third stages agree
  always_comb begin
    miso_d = (miso_s[1] == miso_s[2]) ? miso_s[2] : miso_q;
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      miso_s <= 3'h0;
      miso_q <= 1'b0;
    end else begin
      miso_s <= {miso_s[1:0], miso_in};
      miso_q <= miso_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Queue store: words and command bytes written by the host side, results kept per slot
  always_ff @(posedge clock_in) begin
    if (queue_write_in) begin
      tx_mem[queue_index_in]  <= queue_tx_word_in;
      cmd_mem[queue_index_in] <= queue_cmd_in;
    end
    if (complete) begin
      rx_mem[ptr_q] <= rx_q;
    end
  end

  // Result readback comes out of a register, one cycle after the index
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rx_word_out <= `QS_WORD_RESET;
    end else begin
      rx_word_out <= rx_mem[rx_index_in];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer: one entry is select, pre delay, shift, hold, optional post delay
  always_comb begin
    state_d  = state_q;
    cmd_d    = cmd_q;
    tx_d     = tx_q;
    rx_d     = rx_q;
    cnt_d    = (cnt_q != 16'h0000) ? cnt_q - 16'h0001 : cnt_q;
    pre_d    = pre_q;
    bits_d   = bits_q;
    idx_d    = idx_q;
    ptr_d    = ptr_q;
    cs_d     = cs_q;
    sck_d    = sck_q;
    mosi_d   = mosi_q;
    done_d   = done_q;
    halt_d   = halt_q;
    fin_d    = fin_q;
    launch   = 1'b0;
    complete = 1'b0;
    lp       = ptr_q;
    half     = half_cycles(clock_divider_in);
    len      = `QS_DEFAULT_BITS;
    case (state_q)
      queued_spi_pkg::ST_IDLE: begin
        if (start_in) begin
          lp     = queue_start_pointer_in;
          launch = 1'b1;
        end
      end
      queued_spi_pkg::ST_PRE: begin
        if (cnt_q == 16'h0000) begin
          sck_d   = 1'b1;
          rx_d    = {rx_q[14:0], miso_q};
          cnt_d   = half - 16'h0001;
          state_d = queued_spi_pkg::ST_SHIFT;
        end
      end
      queued_spi_pkg::ST_SHIFT: begin
        if (cnt_q == 16'h0000) begin
          cnt_d = half - 16'h0001;
          if (sck_q) begin
            sck_d = 1'b0;
            if (idx_q == 5'h00) begin
              state_d = queued_spi_pkg::ST_HOLD;
            end else begin
              idx_d  = idx_q - 5'h01;
              mosi_d = tx_q[4'(idx_q - 5'h01)];
            end
          end else begin
            sck_d = 1'b1;
            rx_d  = {rx_q[14:0], miso_q};
          end
        end
      end
      queued_spi_pkg::ST_HOLD: begin
        // Waits on a full FIFO here, so selects stay put rather than dropping a word
        // A stop in the completion cycle wins, so no word is pushed and no flag is set
        if (cnt_q == 16'h0000 && fifo_ready && !stop_in) begin
          complete = 1'b1;
          done_d   = ptr_q;
          cs_d     = cmd_q.chip_select_hold ? cs_q : default_selects_in;
          lp       = ptr_q + 4'h1;
          if (ptr_q == queue_end_pointer_in) begin
            fin_d = 1'b1;
            if (queue_wrap_enable_in) begin
              lp = wrap_target_select_in ? queue_start_pointer_in : 4'h0;
            end else begin
              halt_d = 1'b1;
            end
          end
          ptr_d = lp;
          if (cmd_q.post_transfer_delay_enable && post_transfer_delay_count_in != 8'h00) begin
            cnt_d   = {3'h0, post_transfer_delay_count_in, 5'h00} - 16'h0001;
            state_d = queued_spi_pkg::ST_POST;
          end else if (ptr_q == queue_end_pointer_in && !queue_wrap_enable_in) begin
            state_d = queued_spi_pkg::ST_IDLE;
          end else begin
            launch = 1'b1;
          end
        end
      end
      queued_spi_pkg::ST_POST: begin
        if (cnt_q == 16'h0000) begin
          if (halt_q) begin
            state_d = queued_spi_pkg::ST_IDLE;
          end else begin
            launch = 1'b1;
          end
        end
      end
      default: begin
        state_d = queued_spi_pkg::ST_IDLE;
      end
    endcase
    // Entry start: selects first, then the pre-clock wait counts from them
    if (launch) begin
      cmd_d   = cmd_mem[lp];
      tx_d    = tx_mem[lp];
      ptr_d   = lp;
      halt_d  = 1'b0;
      cs_d    = cmd_mem[lp].peripheral_selects;
      len     = cmd_mem[lp].word_length_enable ? word_bits_in : `QS_DEFAULT_BITS;
      bits_d  = len;
      idx_d   = len - 5'h01;
      mosi_d  = tx_mem[lp][4'(len - 5'h01)];
      pre_d   = (cmd_mem[lp].pre_clock_delay_enable && pre_clock_delay_count_in != 8'h00)
              ? {8'h00, pre_clock_delay_count_in} : half;
      cnt_d   = pre_d - 16'h0001;
      rx_d    = 16'h0000;
      state_d = queued_spi_pkg::ST_PRE;
    end
    // A stop ends everything at once; the flag clear loses to a same-cycle set
    if (stop_in) begin
      state_d = queued_spi_pkg::ST_IDLE;
      sck_d   = 1'b0;
      cs_d    = default_selects_in;
    end
    if (clear_finished_in && !(complete && ptr_q == queue_end_pointer_in)) begin
      fin_d = 1'b0;
    end
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_q <= queued_spi_pkg::ST_IDLE;
      cmd_q   <= `QS_CMD_RESET;
      tx_q    <= `QS_WORD_RESET;
      rx_q    <= `QS_WORD_RESET;
      cnt_q   <= `QS_COUNT_RESET;
      pre_q   <= `QS_COUNT_RESET;
      bits_q  <= `QS_DEFAULT_BITS;
      idx_q   <= 5'h00;
      ptr_q   <= 4'h0;
      cs_q    <= `QS_SELECTS_RESET;
      sck_q   <= 1'b0;
      mosi_q  <= 1'b0;
      done_q  <= 4'h0;
      halt_q  <= 1'b0;
      fin_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      cmd_q   <= cmd_d;
      tx_q    <= tx_d;
      rx_q    <= rx_d;
      cnt_q   <= cnt_d;
      pre_q   <= pre_d;
      bits_q  <= bits_d;
      idx_q   <= idx_d;
      ptr_q   <= ptr_d;
      cs_q    <= cs_d;
      sck_q   <= sck_d;
      mosi_q  <= mosi_d;
      done_q  <= done_d;
      halt_q  <= halt_d;
      fin_q   <= fin_d;
    end
  end

  assign running_out             = (state_q != queued_spi_pkg::ST_IDLE);
  assign queue_finished_flag_out = fin_q;
  assign completed_pointer_out   = done_q;
  assign sck_out                 = sck_q;
  assign mosi_out                = mosi_q;
  assign peripheral_selects_out  = cs_q;

  ////////////////////////////////////////////////////////////////////////////
  // Every completed word is also streamed out with its entry number
  assign push_data = '{entry: ptr_q, word: rx_q};

  result_fifo #(
    .WIDTH ($bits(queued_spi_pkg::result_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clock_in      (clock_in),
    .reset_n_in    (reset_n_in),
    .in_valid_in   (complete),
    .in_ready_out  (fifo_ready),
    .in_data_in    (push_data),
    .out_valid_out (fifo_valid),
    .out_ready_in  (result_ready_in),
    .out_data_out  (result_data_out)
  );

  assign result_valid_out = fifo_valid;

  ////////////////////////////////////////////////////////////////////////////
  // Helper counters read only by the checks below
  logic [15:0] phase_age_q, launch_age_q, fall_age_q, post_age_q;
  logic [4:0]  rises_q;

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      phase_age_q  <= 16'h0000;
      launch_age_q <= 16'h0000;
      fall_age_q   <= 16'h0000;
      post_age_q   <= 16'h0000;
      rises_q      <= 5'h00;
    end else begin
      phase_age_q  <= (sck_d != sck_q) ? 16'h0001 : phase_age_q + 16'h0001;
      launch_age_q <= launch ? 16'h0001 : launch_age_q + 16'h0001;
      fall_age_q   <= (sck_q && !sck_d) ? 16'h0001 : fall_age_q + 16'h0001;
      post_age_q   <= (state_q == queued_spi_pkg::ST_POST) ? post_age_q + 16'h0001 : 16'h0000;
      rises_q      <= launch ? 5'h00 : rises_q + {4'h0, (!sck_q && sck_d)};
    end
  end

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!reset_n_in);

  property p_sck_idle_low;
    (state_q != queued_spi_pkg::ST_SHIFT) && !$past(stop_in) |-> !sck_q || $fell(state_q[2]);
  endproperty
  a_sck_idle_low: assert property (p_sck_idle_low) else $error("sck high outside shift");

  property p_mosi_stable_high;
    sck_q && $past(sck_q) |-> $stable(mosi_q);
  endproperty
  a_mosi_stable_high: assert property (p_mosi_stable_high) else $error("mosi moved while sck high");

  property p_phase_half;
    $past(state_q == queued_spi_pkg::ST_SHIFT) && $changed(sck_q) && !$past(stop_in)
      |-> $past(phase_age_q) == half_cycles(clock_divider_in);
  endproperty
  a_phase_half: assert property (p_phase_half) else $error("sck phase not half period");

  property p_pre_delay;
    $rose(sck_q) && $past(state_q == queued_spi_pkg::ST_PRE) |-> $past(launch_age_q) == pre_q;
  endproperty
  a_pre_delay: assert property (p_pre_delay) else $error("first edge not at pre delay");

  property p_hold_half;
    $past(complete) |-> $past(fall_age_q) >= half_cycles(clock_divider_in);
  endproperty
  a_hold_half: assert property (p_hold_half) else $error("selects changed before half period");

  property p_post_len;
    $past(state_q == queued_spi_pkg::ST_POST) && state_q == queued_spi_pkg::ST_PRE
      |-> $past(post_age_q) + 16'h0001 == {3'h0, post_transfer_delay_count_in, 5'h00};
  endproperty
  a_post_len: assert property (p_post_len) else $error("post delay length wrong");

  property p_bit_count;
    complete |-> rises_q == bits_q;
  endproperty
  a_bit_count: assert property (p_bit_count) else $error("wrong number of bits");

  property p_finish_flag;
    complete && ptr_q == queue_end_pointer_in |=> fin_q ##1 fin_q || $past(clear_finished_in);
  endproperty
  a_finish_flag: assert property (p_finish_flag) else $error("finished flag not set");

  property p_wrap_target;
    complete && ptr_q == queue_end_pointer_in && queue_wrap_enable_in && !wrap_target_select_in
      |=> ptr_q == 4'h0;
  endproperty
  a_wrap_target: assert property (p_wrap_target) else $error("wrap did not go to entry 0");

endmodule

// [shared/queued_spi_consts.svh]
// Timing counts, field positions and reset values of the queued converter-scan master.
// Assumes inclusion by bare name from the design files; definitions only.
`ifndef QUEUED_SPI_CONSTS_SVH
`define QUEUED_SPI_CONSTS_SVH

// System clock period in ns (25 MHz)
`define QS_CLOCK_PERIOD_NS     40
// Word length used when an entry does not enable its own length
`define QS_DEFAULT_BITS        5'h08
// Word length programmed for 10-bit converter exchanges
`define QS_WORD_BITS_RESET     5'h0a
// Post-transfer delay unit as log2 of its length in system clock cycles (32)
`define QS_POST_UNIT_SHIFT     5
// Queue entry count and pointer width
`define QS_QUEUE_DEPTH         16
`define QS_PTR_BITS            4
// Transmit and receive word width
`define QS_WORD_WIDTH          16
// Result FIFO depth
`define QS_FIFO_DEPTH          16
// Command byte field positions
`define QS_CMD_HOLD_BIT        7
`define QS_CMD_LEN_BIT         6
`define QS_CMD_POST_BIT        5
`define QS_CMD_PRE_BIT         4
// Reset values of pins and stored state
`define QS_SELECTS_RESET       4'hf
`define QS_WORD_RESET          16'h0000
`define QS_CMD_RESET           8'h00
`define QS_COUNT_RESET         16'h0000

`endif

// [shared/queued_spi_pkg.sv]
// Types shared by the queued converter-scan master and its result FIFO.
// Assumes the constants header is compiled alongside; nothing is imported.
package queued_spi_pkg;

  // Per-entry command byte, most significant field first
  typedef struct packed {
    logic       chip_select_hold;
    logic       word_length_enable;
    logic       post_transfer_delay_enable;
    logic       pre_clock_delay_enable;
    logic [3:0] peripheral_selects;
  } cmd_t;

  // One received word together with the entry that captured it
  typedef struct packed {
    logic [3:0]  entry;
    logic [15:0] word;
  } result_t;

  // Sequencer states, one-hot
  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_PRE   = 5'h02,
    ST_SHIFT = 5'h04,
    ST_HOLD  = 5'h08,
    ST_POST  = 5'h10
  } state_t;

endpackage

// [design/result_fifo.sv]
// Result FIFO: a small word store with a registered output stage.
// Assumes one clock; the drain side may stall, which back-pressures the scanner.
`timescale 1ns/10ps
module result_fifo #(
  parameter int WIDTH = 20,
  parameter int DEPTH = 16
) (
  input  wire logic             clock_in,
  input  wire logic             reset_n_in,
  input  wire logic             in_valid_in,
  output      logic             in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output      logic             out_valid_out,
  input  wire logic             out_ready_in,
  output      logic [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
  logic [AW:0]      count_q, count_d;
  logic             valid_q, valid_d;
  logic [WIDTH-1:0] data_q, data_d;
  logic             push, pop;

  //////////////////////////////////////////////////////////////////////////
  // Next pointers; the output register refills whenever it empties or is taken
  always_comb begin
    push    = in_valid_in && in_ready_out;
    pop     = (!valid_q || out_ready_in) && (count_q != '0);
    wr_d    = push ? wr_q + 1'b1 : wr_q;
    rd_d    = pop ? rd_q + 1'b1 : rd_q;
    count_d = count_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    valid_d = pop ? 1'b1 : (out_ready_in ? 1'b0 : valid_q);
    data_d  = pop ? mem_q[rd_q] : data_q;
  end

  // Full is honest: no write is taken while every slot holds a word
  assign in_ready_out  = (count_q != (AW+1)'(DEPTH));
  assign out_valid_out = valid_q;
  assign out_data_out  = data_q;

  //////////////////////////////////////////////////////////////////////////
  // Storage has no reset; only the pointers, the count and the output stage do
  always_ff @(posedge clock_in) begin
    if (push) begin
      mem_q[wr_q] <= in_data_in;
    end
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wr_q    <= '0;
      rd_q    <= '0;
      count_q <= '0;
      valid_q <= 1'b0;
      data_q  <= '0;
    end else begin
      wr_q    <= wr_d;
      rd_q    <= rd_d;
      count_q <= count_d;
      valid_q <= valid_d;
      data_q  <= data_d;
    end
  end

endmodule

// [tb/adc_model.sv]
// Behavioural serial converter on the far side of the scan master.
// Assumes an active-low select on selects bit 0 and 10-bit exchanges.
`timescale 1ns/10ps
module adc_model (
  input  wire logic sck_in,
  input  wire logic cs_n_in,
  input  wire logic mosi_in,
  output      logic miso_out
);
  logic [9:0] in_q;
  logic [9:0] out_q;
  logic [3:0] chan_q;
  logic       warm_q = 1'b0;
  int         bits_q = 0;
  // Result coding, private to the model
  function automatic logic [9:0] code(input logic [3:0] a);
    return {a, 2'b10, ~a};
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  // Select loads the result asked for last time; the first word is junk
  always @(negedge cs_n_in) begin
    out_q = warm_q ? code(chan_q) : 10'h155;
    miso_out = out_q[9];
    bits_q = 0;
  end
  // Sample on rising edges, shift on falling edges, only while selected
  always @(posedge sck_in) if (!cs_n_in) begin
    in_q = {in_q[8:0], mosi_in};
    bits_q++;
  end
  always @(negedge sck_in) if (!cs_n_in) begin
    out_q = {out_q[8:0], 1'b0};
    miso_out = out_q[9];
  end
  // Released line has no pull, so it shows the inverse of the last level
  always @(posedge cs_n_in) begin
    miso_out = ~miso_out;
    if (bits_q == 10) begin
      chan_q = in_q[9:6];
      warm_q = 1'b1;
    end
  end
  initial miso_out = 1'b0;
endmodule

// [tb/queued_spi_scan_tb.sv]
// Self-checking bench for the queued converter-scan master.
// Assumes the converter model on select bit 0 and the design's 16-word result FIFO.
`timescale 1ns/10ps
module queued_spi_scan_tb;
  logic clock_in, reset_n_in, queue_write_in, queue_wrap_enable_in, wrap_target_select_in;
  logic start_in, stop_in, clear_finished_in, miso_in, result_ready_in;
  logic [3:0] queue_index_in, rx_index_in, default_selects_in;
  logic [3:0] queue_start_pointer_in, queue_end_pointer_in;
  logic [15:0] queue_tx_word_in;
  queued_spi_pkg::cmd_t queue_cmd_in;
  logic [7:0] clock_divider_in, pre_clock_delay_count_in, post_transfer_delay_count_in;
  logic [4:0] word_bits_in;
  logic [15:0] rx_word_out;
  logic running_out, queue_finished_flag_out, sck_out, mosi_out, result_valid_out;
  logic [3:0] completed_pointer_out, peripheral_selects_out;
  queued_spi_pkg::result_t result_data_out;
  int err_total = 0, num_checks = 0, cyc = 0, ev_c = 0, rises = 0, pops = 0;
  logic [31:0] rnd = 32'ha422cd2f;
  logic [3:0] ch [16];
  logic [3:0] exp_e, prev_e;
  logic mon_on = 1'b0, gap = 1'b0, p_sck = 1'b0, p_cs = 1'b1, len_en, pre_en;
  queued_spi_scan i_dut (.*);
  adc_model i_adc (.sck_in(sck_out), .cs_n_in(peripheral_selects_out[0]),
                   .mosi_in(mosi_out), .miso_out(miso_in));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [9:0] conv(input logic [3:0] a);
    return {a, 2'b10, ~a};
  endfunction
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    num_checks++;
    if (s !== e) begin
      $display("unexpected %s expected %h seen %h", n, e, s);
      err_total++;
    end
  endtask
  task automatic complete_run();
    if (err_total == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Back-to-back queue writes; entry k uses channel ch[k]
  task automatic wr(input logic [3:0] k, input queued_spi_pkg::cmd_t c);
    queue_write_in <= 1'b1;
    queue_index_in <= k;
    queue_tx_word_in <= {6'h00, ch[k], 6'h00};
    queue_cmd_in <= c;
    @(posedge clock_in);
  endtask
  task automatic run(input logic [3:0] s, input logic [3:0] e, input logic t);
    queue_write_in <= 1'b0;
    queue_start_pointer_in <= s;
    queue_end_pointer_in <= e;
    wrap_target_select_in <= t;
    start_in <= 1'b1;
    gap = 1'b0;
    mon_on = 1'b1;
    @(posedge clock_in);
    start_in <= 1'b0;
  endtask
  task automatic halt_drain(input logic [3:0] nxt);
    int i;
    stop_in <= 1'b1;
    clear_finished_in <= 1'b1;
    @(posedge clock_in);
    stop_in <= 1'b0;
    clear_finished_in <= 1'b0;
    mon_on = 1'b0;
    repeat (2) @(posedge clock_in);
    chk("running", 1'b0, running_out);
    chk("flag idle", 1'b0, queue_finished_flag_out);
    chk("selects", 4'hf, peripheral_selects_out);
    result_ready_in <= 1'b1;
    pops = 0;
    for (i = 0; i < 40; i++) @(posedge clock_in);
    exp_e = nxt;
  endtask
  task automatic wait_flag();
    int i;
    for (i = 0; i < 4000 && queue_finished_flag_out !== 1'b1; i++) @(posedge clock_in);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard
  initial begin
    clock_in = 1'b0;
    forever #20 clock_in = ~clock_in;
  end
  always @(posedge clock_in) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      complete_run();
    end
  end
  // Pin timing and result stream monitor; reads values from before each edge
  always @(posedge clock_in) begin
    ev_c++;
    if (result_valid_out && result_ready_in) begin
      chk("entry", exp_e, result_data_out.entry);
      // Each 10-bit word carries the channel asked for by the entry before it
      if (len_en && exp_e != 4'hf)
        chk("word", {6'h00, conv(ch[prev_e])}, result_data_out.word);
      prev_e = exp_e;
      exp_e = (exp_e == queue_end_pointer_in) ?
              (wrap_target_select_in ? queue_start_pointer_in : 4'h0) : exp_e + 4'h1;
      pops++;
    end
    if (mon_on && p_cs && !peripheral_selects_out[0]) begin
      if (gap) chk("post gap", 32 * post_transfer_delay_count_in, ev_c);
      ev_c = 0;
      rises = 0;
    end else if (mon_on && sck_out !== p_sck) begin
      if (rises == 0) chk("pre", pre_en ? pre_clock_delay_count_in : clock_divider_in, ev_c);
      else chk("phase", clock_divider_in, ev_c);
      if (sck_out) rises++;
      ev_c = 0;
    end else if (mon_on && !p_cs && peripheral_selects_out[0]) begin
      chk("cs hold", clock_divider_in, ev_c);
      chk("bits", len_en ? 10 : 8, rises);
      ev_c = 0;
      gap = 1'b1;
    end
    p_sck = sck_out;
    p_cs = peripheral_selects_out[0];
  end
  // Stimulus: ready is random while scanning
  always @(posedge clock_in) begin
    rnd <= lfsr(rnd);
    if (mon_on) result_ready_in <= rnd[3];
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin : main
    int k;
    {reset_n_in, queue_write_in, queue_wrap_enable_in, wrap_target_select_in} = 4'h0;
    {start_in, stop_in, clear_finished_in, result_ready_in} = 4'h0;
    {queue_index_in, rx_index_in, queue_start_pointer_in, queue_end_pointer_in} = 16'h0000;
    default_selects_in = 4'hf;
    queue_tx_word_in = 16'h0000;
    queue_cmd_in = 8'h00;
    word_bits_in = 5'h0a;
    clock_divider_in = 8'h04 + {6'h00, rnd[1:0]};
    pre_clock_delay_count_in = 8'h08 + {3'h0, rnd[8:4]};
    post_transfer_delay_count_in = 8'h01 + {6'h00, rnd[11:10]};
    for (k = 0; k < 16; k++) ch[k] = rnd[k+:4] ^ k[3:0];
    repeat (10) @(posedge clock_in);
    reset_n_in <= 1'b1;
    @(posedge clock_in);
    chk("reset", 7'h78, {peripheral_selects_out, sck_out, running_out, queue_finished_flag_out});
    // Scan: F once, then 0-2 forever; long delays and 10-bit words
    len_en = 1'b1;
    pre_en = 1'b1;
    queue_wrap_enable_in <= 1'b1;
    wr(4'hf, 8'h7e);
    for (k = 0; k < 3; k++) wr(k[3:0], 8'h7e);
    exp_e = 4'hf;
    run(4'hf, 4'h2, 1'b0);
    wait_flag();
    chk("flag", 1'b1, queue_finished_flag_out);
    chk("done ptr", 4'h2, completed_pointer_out);
    for (k = 0; k < 3; k++) begin
      rx_index_in <= k[3:0];
      repeat (2) @(posedge clock_in);
      chk("rx slot", {6'h00, conv(ch[(k + 15) % 16])}, rx_word_out);
    end
    clear_finished_in <= 1'b1;
    @(posedge clock_in);
    clear_finished_in <= 1'b0;
    repeat (2) @(posedge clock_in);
    chk("flag clear", 1'b0, queue_finished_flag_out);
    repeat (1500) @(posedge clock_in);
    halt_drain(4'h1);
    // Wrap to start pointer, default length, short pre-clock delay
    len_en = 1'b0;
    pre_en = 1'b0;
    wr(4'h1, 8'h2e);
    wr(4'h2, 8'h2e);
    run(4'h1, 4'h2, 1'b1);
    wait_flag();
    chk("flag", 1'b1, queue_finished_flag_out);
    repeat (600) @(posedge clock_in);
    halt_drain(4'h1);
    // Fill the result FIFO with the drain stalled, then count what comes out
    result_ready_in <= 1'b0;
    run(4'h1, 4'h2, 1'b1);
    mon_on = 1'b0;
    @(posedge clock_in);
    result_ready_in <= 1'b0;
    repeat (5000) @(posedge clock_in);
    chk("stalled", 1'b1, running_out);
    halt_drain(4'h1);
    chk("fifo words", 17, pops);
    complete_run();
  end
endmodule
